// ===== design/mtcs_map.svh
// register offsets, field positions, reset values and byte counts of the transmit control block
`ifndef MTCS_MAP_SVH
`define MTCS_MAP_SVH
`define MTCS_IDX_TX_CTRL 6'h00
`define MTCS_IDX_TX_STAT 6'h02
`define MTCS_IDX_TX_ENG 6'h0A
`define MTCS_IDX_FLOW_CFG 6'h0C
`define MTCS_IDX_BANK_SEL 6'h0E
`define MTCS_BANK_TX 6'h10
`define MTCS_BANK_RSV_LO 6'h08
`define MTCS_BANK_RSV_HI 6'h0F
`define MTCS_CTRL_RUN 0
`define MTCS_CTRL_FCS 1
`define MTCS_CTRL_PAD 2
`define MTCS_CTRL_FLOW 3
`define MTCS_CTRL_RW_MASK 16'h600F
`define MTCS_CTRL_RST 16'h0000
`define MTCS_CFG_RESTART 15
`define MTCS_CFG_THR_RST 13'h1000
`define MTCS_BANK_RST 6'h00
`define MTCS_MIN_FRAME 11'h040
`define MTCS_FCS_BYTES 11'h004
`define MTCS_PAUSE_BYTES 11'h03C
`define MTCS_CRC_INIT 32'hFFFFFFFF
`define MTCS_CRC_POLY 32'hEDB88320
`endif

// ===== design/mtcs_pkg.sv
// types shared by the transmit control block
package mtcs_pkg;
  typedef struct packed {
    logic [5:0] tag;
    logic last;
    logic [7:0] data;
  } mtcs_word_s;
  typedef struct packed {
    logic underrun;
    logic late_coll;
    logic max_coll;
    logic [5:0] tag;
  } mtcs_transmit_status_s;
  typedef struct packed {
    logic valid;
    logic last;
    logic abort;
    logic [7:0] data;
  } mtcs_link_s;
  typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_PAD, ST_FCS, ST_PAUSE, ST_HALT} mtcs_state_e;
endpackage

// ===== design/mtcs_tx.sv
// transmit control and status: apb registers, frame fifo, frame engine with pad, fcs and pause
`timescale 1ns/1ps
`include "mtcs_map.svh"

// ----------------------------------------
// frame fifo
// ----------------------------------------
module mtcs_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// transmit control top
// ----------------------------------------
module mtcs_tx #(
  parameter int FIFO_DEPTH = 4,
  parameter int LEVEL_W = 13,
  parameter logic [47:0] STATION_ADDR = 48'h000000000000,
  parameter logic [15:0] PAUSE_QUANTA = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire mtcs_pkg::mtcs_word_s in_word,
  output mtcs_pkg::mtcs_link_s link_out,
  input wire logic link_ready,
  input wire logic full_duplex,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic coll_late,
  input wire logic coll_max,
  output logic back_pressure
);
  import mtcs_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mtcs_state_e state_r;
  mtcs_transmit_status_s transmit_status_r;
  mtcs_link_s out_r;
  mtcs_word_s fifo_word;
  logic [15:0] ctrl_r;
  logic [LEVEL_W-1:0] thr_r;
  logic [5:0] bank_r, tag_r, idx;
  logic [31:0] rdata_r, crc_r, rd_val;
  logic [10:0] cnt_r, pad_min;
  logic [7:0] pause_byte, fcs_byte;
  logic lc_r, mc_r, pause_pend_r, over_r, pause_run_r;
  logic fifo_valid, fifo_pop, restart, load, done, over, in_bank, mapped;

  // ----------------------------------------
  // crc and pause frame helpers
  // ----------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ `MTCS_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [7:0] pause_at(input logic [10:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      11'h000: b = 8'h01;
      11'h001: b = 8'h80;
      11'h002: b = 8'hC2;
      11'h005: b = 8'h01;
      11'h006: b = STATION_ADDR[47:40];
      11'h007: b = STATION_ADDR[39:32];
      11'h008: b = STATION_ADDR[31:24];
      11'h009: b = STATION_ADDR[23:16];
      11'h00A: b = STATION_ADDR[15:8];
      11'h00B: b = STATION_ADDR[7:0];
      11'h00C: b = 8'h88;
      11'h00D: b = 8'h08;
      11'h00F: b = 8'h01;
      11'h010: b = PAUSE_QUANTA[15:8];
      11'h011: b = PAUSE_QUANTA[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait states; read data is caught in the setup cycle so it comes from a flop
  assign idx = paddr[7:2];
  assign in_bank = (bank_r == `MTCS_BANK_TX);
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[31:8] == '0) &&
                  ((idx == `MTCS_IDX_BANK_SEL) || (in_bank && ((idx == `MTCS_IDX_TX_CTRL) ||
                  (idx == `MTCS_IDX_TX_STAT) || (idx == `MTCS_IDX_TX_ENG) || (idx == `MTCS_IDX_FLOW_CFG))));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_r;
  assign restart = psel && penable && pwrite && mapped && (idx == `MTCS_IDX_FLOW_CFG) && pwdata[`MTCS_CFG_RESTART];

  always_comb begin
    rd_val = 32'h00000000;
    if (idx == `MTCS_IDX_BANK_SEL) begin
      rd_val = {26'h0, bank_r};
    end else if (in_bank) begin
      unique case (idx)
        `MTCS_IDX_TX_CTRL: rd_val = {16'h0, ctrl_r};
        `MTCS_IDX_TX_STAT: rd_val = {17'h0, transmit_status_r.underrun, transmit_status_r.late_coll, transmit_status_r.max_coll, 6'h00, transmit_status_r.tag};
        `MTCS_IDX_TX_ENG: rd_val = {28'h0, !in_ready, back_pressure, (state_r == ST_HALT), (state_r != ST_IDLE)};
        `MTCS_IDX_FLOW_CFG: rd_val = {{(32-LEVEL_W){1'b0}}, thr_r};
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      rdata_r <= mapped ? rd_val : 32'h00000000;
    end
  end

  // reserved banks take no writes; only the bank select sees every bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_r <= `MTCS_BANK_RST;
      ctrl_r <= `MTCS_CTRL_RST;
      thr_r <= `MTCS_CFG_THR_RST;
    end else if (psel && penable && pwrite && mapped) begin
      if (idx == `MTCS_IDX_BANK_SEL) begin
        bank_r <= pwdata[5:0];
      end else if (idx == `MTCS_IDX_TX_CTRL) begin
        ctrl_r <= pwdata[15:0] & `MTCS_CTRL_RW_MASK;
      end else if (idx == `MTCS_IDX_FLOW_CFG) begin
        thr_r <= pwdata[LEVEL_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // frame fifo
  // ----------------------------------------
  mtcs_fifo #(
    .WIDTH($bits(mtcs_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(restart),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  // ----------------------------------------
  // flow control
  // ----------------------------------------
  assign over = ctrl_r[`MTCS_CTRL_FLOW] && (rx_level >= thr_r);
  assign back_pressure = over && !full_duplex;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_r <= 1'b0;
      pause_pend_r <= 1'b0;
      pause_run_r <= 1'b0;
    end else begin
      over_r <= over && full_duplex;
      // a new crossing wins over the clear taken when the pause frame starts
      if (over && full_duplex && !over_r) begin
        pause_pend_r <= 1'b1;
      end else if (state_r == ST_IDLE && load && pause_pend_r && !restart) begin
        pause_pend_r <= 1'b0;
      end
      // start wins over done, so a pause queued right behind a frame stays marked
      if (restart) begin
        pause_run_r <= 1'b0;
      end else if (state_r == ST_IDLE && load && pause_pend_r) begin
        pause_run_r <= 1'b1;
      end else if (done) begin
        pause_run_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  assign load = !out_r.valid || link_ready;
  assign pad_min = ctrl_r[`MTCS_CTRL_FCS] ? (`MTCS_MIN_FRAME - `MTCS_FCS_BYTES) : `MTCS_MIN_FRAME;
  assign fifo_pop = load && fifo_valid &&
                    ((state_r == ST_DATA) || (state_r == ST_IDLE && !pause_pend_r && ctrl_r[`MTCS_CTRL_RUN]));
  assign pause_byte = pause_at(cnt_r);
  assign fcs_byte = ~crc_r[cnt_r[1:0]*8 +: 8];
  assign done = out_r.valid && out_r.last && link_ready;
  assign link_out = out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      out_r <= '0;
      cnt_r <= '0;
      crc_r <= `MTCS_CRC_INIT;
      tag_r <= '0;
    end else if (restart) begin
      state_r <= ST_IDLE;
      out_r <= '0;
    end else if (load) begin
      out_r <= '0;
      unique case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          crc_r <= `MTCS_CRC_INIT;
          if (pause_pend_r) begin
            // pause frames skip the fifo and do not touch the status register
            state_r <= ST_PAUSE;
          end else if (ctrl_r[`MTCS_CTRL_RUN] && fifo_valid) begin
            tag_r <= fifo_word.tag;
            out_r <= '{valid: 1'b1, last: 1'b0, abort: 1'b0, data: fifo_word.data};
            crc_r <= crc_byte(`MTCS_CRC_INIT, fifo_word.data);
            cnt_r <= 11'h001;
            state_r <= ST_DATA;
            if (fifo_word.last) begin
              out_r.last <= !(ctrl_r[`MTCS_CTRL_PAD] && 11'h001 < pad_min) && !ctrl_r[`MTCS_CTRL_FCS];
              state_r <= (ctrl_r[`MTCS_CTRL_PAD] && 11'h001 < pad_min) ? ST_PAD :
                         ctrl_r[`MTCS_CTRL_FCS] ? ST_FCS : ST_IDLE;
              cnt_r <= (ctrl_r[`MTCS_CTRL_PAD] && 11'h001 < pad_min) ? 11'h001 : '0;
            end
          end
        end
        // run bit is not looked at here, so a cleared run bit lets the frame finish
        ST_DATA: begin
          if (fifo_valid) begin
            out_r <= '{valid: 1'b1, last: 1'b0, abort: 1'b0, data: fifo_word.data};
            crc_r <= crc_byte(crc_r, fifo_word.data);
            cnt_r <= cnt_r + 11'h001;
            if (fifo_word.last) begin
              if (ctrl_r[`MTCS_CTRL_PAD] && (cnt_r + 11'h001) < pad_min) begin
                state_r <= ST_PAD;
              end else if (ctrl_r[`MTCS_CTRL_FCS]) begin
                state_r <= ST_FCS;
                cnt_r <= '0;
              end else begin
                out_r.last <= 1'b1;
                state_r <= ST_IDLE;
              end
            end
          end else if (out_r.valid) begin
            // the link drained the last byte and nothing follows: fatal underrun
            out_r <= '{valid: 1'b1, last: 1'b1, abort: 1'b1, data: 8'h00};
            state_r <= ST_HALT;
          end
        end
        ST_PAD: begin
          out_r <= '{valid: 1'b1, last: 1'b0, abort: 1'b0, data: 8'h00};
          crc_r <= crc_byte(crc_r, 8'h00);
          cnt_r <= cnt_r + 11'h001;
          if ((cnt_r + 11'h001) >= pad_min) begin
            if (ctrl_r[`MTCS_CTRL_FCS]) begin
              state_r <= ST_FCS;
              cnt_r <= '0;
            end else begin
              out_r.last <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_PAUSE: begin
          out_r <= '{valid: 1'b1, last: 1'b0, abort: 1'b0, data: pause_byte};
          crc_r <= crc_byte(crc_r, pause_byte);
          cnt_r <= cnt_r + 11'h001;
          if ((cnt_r + 11'h001) >= `MTCS_PAUSE_BYTES) begin
            state_r <= ST_FCS;
            cnt_r <= '0;
          end
        end
        ST_FCS: begin
          out_r <= '{valid: 1'b1, last: (cnt_r == `MTCS_FCS_BYTES - 11'h001), abort: 1'b0,
                     data: fcs_byte};
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == `MTCS_FCS_BYTES - 11'h001) begin
            state_r <= ST_IDLE;
          end
        end
        ST_HALT: state_r <= ST_HALT;
      endcase
    end
  end

  // ----------------------------------------
  // transmit status
  // ----------------------------------------
  // collision flags gather over the frame; a pulse in the completing cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_r <= 1'b0;
      mc_r <= 1'b0;
    end else if (done || restart) begin
      lc_r <= 1'b0;
      mc_r <= 1'b0;
    end else if (state_r != ST_IDLE || out_r.valid) begin
      lc_r <= lc_r || coll_late;
      mc_r <= mc_r || coll_max;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_status_r <= '0;
    end else if (done && !pause_run_r) begin
      transmit_status_r <= '{underrun: out_r.abort, late_coll: lc_r || coll_late, max_coll: mc_r || coll_max,
                  tag: tag_r};
    end
  end
endmodule

// ===== verification/mtcs_link_sink.sv
// link-side partner that takes bytes from the block
`timescale 1ns/1ps
module mtcs_link_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire mtcs_pkg::mtcs_link_s link_out,
  output logic link_ready
);
  import mtcs_pkg::*;
  mtcs_link_s q[$];
  // stalling takes a byte every other cycle so the fifo must hold data back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ready <= 1'h0;
    end else begin
      if (link_out.valid && link_ready) begin
        q.push_back(link_out);
      end
      link_ready <= stall ? !link_ready : 1'h1;
    end
  end
endmodule

// ===== verification/mtcs_tx_asserts.sv
// concurrent checks on the ports of the transmit control block
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module mtcs_tx_chk #(
  parameter int LEVEL_W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire mtcs_pkg::mtcs_word_s in_word,
  input wire mtcs_pkg::mtcs_link_s link_out,
  input wire logic link_ready,
  input wire logic full_duplex,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic coll_late,
  input wire logic coll_max,
  input wire logic back_pressure
);
  import mtcs_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  unaligned_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  rd_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  byte_hold_a: assert property (link_out.valid && !link_ready |=> $stable(link_out))
    else $error("link byte changed before taken");
  abort_last_a: assert property (link_out.valid && link_out.abort |-> link_out.last)
    else $error("abort byte does not end the frame");
  halt_quiet_a: assert property (link_out.valid && link_out.abort && link_ready |=> !link_out.valid [*3])
    else $error("bytes sent right after an underrun");
  bp_half_a: assert property (back_pressure |-> !full_duplex)
    else $error("back-pressure in full duplex");
endmodule

bind mtcs_tx mtcs_tx_chk #(.LEVEL_W(LEVEL_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word), .link_out(link_out),
  .link_ready(link_ready), .full_duplex(full_duplex), .rx_level(rx_level),
  .coll_late(coll_late), .coll_max(coll_max), .back_pressure(back_pressure)
);

// ===== verification/mtcs_tx_tb.sv
// self-checking bench for the transmit control block
`timescale 1ns/1ps
`include "mtcs_map.svh"
module mtcs_tx_tb;
  import mtcs_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, in_valid = 1'h0, full_duplex = 1'h0;
  logic coll_late = 1'h0, coll_max = 1'h0, stall = 1'h1;
  logic pready, pslverr, in_ready, link_ready, back_pressure;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [12:0] rx_level = 13'h0;
  mtcs_word_s in_word = '0;
  mtcs_link_s link_out;
  logic [7:0] exp[$];
  int err_total = 0, checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  mtcs_tx i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word), .link_out(link_out),
    .link_ready(link_ready), .full_duplex(full_duplex), .rx_level(rx_level),
    .coll_late(coll_late), .coll_max(coll_max), .back_pressure(back_pressure)
  );
  mtcs_link_sink i_sink (
    .pclk(pclk), .presetn(presetn), .stall(stall), .link_out(link_out), .link_ready(link_ready)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    chk(pslverr, e);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic st(input logic [15:0] v);
    apb(1'h0, 8'h08, 16'h0, 1'h0);
    chk(rd, {16'h0, v});
  endtask
  // host feeds a byte every cycle, faster than the link drains
  task automatic push(input logic [5:0] t, input int n, input logic l);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'h1;
      in_word <= '{t, l && i == n - 1, 8'(8'hA0 + i)};
      do @(posedge pclk); while (!in_ready);
    end
    in_valid <= 1'h0;
  endtask
  task automatic wait_fr();
    while (!(i_sink.q.size() > 0 && i_sink.q[$].last)) @(posedge pclk);
  endtask
  task automatic frame(input logic f, input logic p);
    logic [31:0] c;
    if (p) while (exp.size() < (f ? 60 : 64)) exp.push_back(8'h00);
    c = `MTCS_CRC_INIT;
    foreach (exp[i]) begin
      c = c ^ exp[i];
      repeat (8) c = c[0] ? (c >> 1) ^ `MTCS_CRC_POLY : c >> 1;
    end
    if (f) for (int j = 0; j < 4; j++) exp.push_back(~c[8*j +: 8]);
    wait_fr();
    chk(i_sink.q.size(), exp.size());
    foreach (exp[i]) if (i < i_sink.q.size()) chk(i_sink.q[i].data, exp[i]);
    i_sink.q.delete();
    exp.delete();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs();
    apb(1'h1, 8'h38, 16'h0008, 1'h0);
    apb(1'h0, 8'h00, 16'h0, 1'h1);
    apb(1'h0, 8'h38, 16'h0, 1'h0);
    chk(rd, 32'h8);
    apb(1'h1, 8'h38, 16'h0010, 1'h0);
    apb(1'h0, 8'h00, 16'h0, 1'h0);
    chk(rd, 32'h0);
    apb(1'h1, 8'h00, 16'hFFF0, 1'h0);
    apb(1'h0, 8'h00, 16'h0, 1'h0);
    chk(rd, 32'h6000);
    apb(1'h0, 8'h02, 16'h0, 1'h1);
    apb(1'h0, 8'h44, 16'h0, 1'h1);
  endtask
  task automatic s_stop();
    apb(1'h1, 8'h00, 16'h0000, 1'h0);
    push(6'h03, 4, 1'h1);
    @(posedge pclk);
    chk(in_ready, 1'h0);
    apb(1'h1, 8'h00, 16'h0001, 1'h0);
    apb(1'h1, 8'h00, 16'h0000, 1'h0);
    for (int i = 0; i < 4; i++) exp.push_back(8'(8'hA0 + i));
    frame(1'h0, 1'h0);
    st(16'h0003);
    push(6'h04, 1, 1'h1);
    repeat (100) @(posedge pclk);
    chk(i_sink.q.size(), 0);
  endtask
  task automatic s_pad();
    exp.push_back(8'hA0);
    apb(1'h1, 8'h00, 16'h0007, 1'h0);
    coll_late <= 1'h1;
    repeat (3) @(posedge pclk);
    coll_late <= 1'h0;
    frame(1'h1, 1'h1);
    st(16'h2004);
    apb(1'h1, 8'h00, 16'h0003, 1'h0);
    push(6'h05, 2, 1'h1);
    coll_max <= 1'h1;
    repeat (2) @(posedge pclk);
    coll_max <= 1'h0;
    exp = {8'hA0, 8'hA1};
    frame(1'h1, 1'h0);
    st(16'h1005);
  endtask
  task automatic s_flow();
    apb(1'h1, 8'h00, 16'h0001, 1'h0);
    rx_level <= 13'h1FFF;
    @(posedge pclk);
    chk(back_pressure, 1'h0);
    apb(1'h1, 8'h00, 16'h0009, 1'h0);
    @(posedge pclk);
    chk(back_pressure, 1'h1);
    full_duplex <= 1'h1;
    rx_level <= 13'h0;
    apb(1'h1, 8'h00, 16'h0001, 1'h0);
    rx_level <= 13'h1FFF;
    repeat (100) @(posedge pclk);
    chk(i_sink.q.size(), 0);
    chk(back_pressure, 1'h0);
    rx_level <= 13'h0;
    apb(1'h1, 8'h00, 16'h0009, 1'h0);
    rx_level <= 13'h1FFF;
    exp = {8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    exp = {exp, 8'h00, 8'h00, 8'h00, 8'h88, 8'h08, 8'h00, 8'h01, 8'hFF, 8'hFF};
    frame(1'h1, 1'h1);
  endtask
  task automatic s_under();
    full_duplex <= 1'h0;
    rx_level <= 13'h0;
    apb(1'h1, 8'h00, 16'h0001, 1'h0);
    push(6'h06, 1, 1'h0);
    wait_fr();
    chk(i_sink.q.size(), 2);
    chk(i_sink.q[1].abort, 1'h1);
    i_sink.q.delete();
    st(16'h4006);
    apb(1'h0, 8'h28, 16'h0, 1'h0);
    chk(rd, 32'h3);
    push(6'h07, 1, 1'h1);
    repeat (100) @(posedge pclk);
    chk(i_sink.q.size(), 0);
    apb(1'h1, 8'h30, 16'h9000, 1'h0);
    apb(1'h0, 8'h30, 16'h0, 1'h0);
    chk(rd, 32'h1000);
    push(6'h08, 1, 1'h1);
    exp.push_back(8'hA0);
    frame(1'h0, 1'h0);
    st(16'h0008);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    s_regs();
    s_stop();
    s_pad();
    s_flow();
    s_under();
    print_verdict();
  end
endmodule
